// ===== core/srdc_pkg.sv
package srdc_pkg;

  // Rate codes, 48 kHz family
  localparam logic [4:0] SRDC_R12K   = 5'h01;
  localparam logic [4:0] SRDC_R24K   = 5'h02;
  localparam logic [4:0] SRDC_R48K   = 5'h03;
  localparam logic [4:0] SRDC_R96K   = 5'h04;
  localparam logic [4:0] SRDC_R192K  = 5'h05;
  localparam logic [4:0] SRDC_R8K    = 5'h11;
  localparam logic [4:0] SRDC_R16K   = 5'h12;
  localparam logic [4:0] SRDC_R32K   = 5'h13;
  // Rate codes, 44.1 kHz family
  localparam logic [4:0] SRDC_R11K   = 5'h09;
  localparam logic [4:0] SRDC_R22K   = 5'h0a;
  localparam logic [4:0] SRDC_R44K   = 5'h0b;
  localparam logic [4:0] SRDC_R88K   = 5'h0c;
  localparam logic [4:0] SRDC_R176K  = 5'h0d;
  localparam logic [4:0] SRDC_RNONE  = 5'h00;

  // Reset value of selectors and applied copies, and clock code maximum
  localparam logic [4:0] SRDC_RATE_RST = 5'h03;
  localparam logic [2:0] SRDC_FREQ_MAX = 3'h4;

  // Microphone clock codes on input paths
  localparam logic [1:0] SRDC_MIC_384K = 2'h1;
  localparam logic [1:0] SRDC_MIC_768K = 2'h2;

  // Counts: selectors, paths, detector
  localparam int SRDC_NSYNC   = 3;
  localparam int SRDC_NASYNC  = 2;
  localparam int SRDC_NSEL    = 5;
  localparam int SRDC_NPATH   = 8;
  localparam int SRDC_NPIN    = 4;
  localparam int SRDC_NCAND   = 4;
  localparam int SRDC_PERW    = 16;

  // Clock and frame period window
  localparam int SRDC_CLK_KHZ = 10000;
  localparam int SRDC_TOL_PCT = 1;
  localparam int SRDC_CONFIRM = 2;

  // Path binding: index 0..2 sync, 3..4 async
  localparam logic [2:0] SRDC_SEL_FIRST_ASYNC = 3'h3;

endpackage

// ===== core/srdc_period_meter.sv
`timescale 1ns/10ps
// Measures frame-clock period in system clocks
module srdc_period_meter
  import srdc_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  frame_i,
  input  wire logic                  run_i,
  output logic                       done_o,
  output logic [SRDC_PERW-1:0]       period_o
);

  typedef struct packed {
    logic                  prev;
    logic                  done;
    logic [SRDC_PERW-1:0]  cnt;
    logic [SRDC_PERW-1:0]  period;
  } srdc_pm_t;

  srdc_pm_t st_ff;
  srdc_pm_t nxt_st;

  // Rising edge closes a period; counter saturates on a stopped clock
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.prev = frame_i;
    nxt_st.done = 1'b0;
    if (!run_i)
    begin
      nxt_st.cnt = '0;
    end
    else if (frame_i && !st_ff.prev)
    begin
      nxt_st.period = st_ff.cnt;
      nxt_st.done   = 1'b1;
      // Edge cycle is the first clock of the next period, else every period reads one short
      nxt_st.cnt    = {{(SRDC_PERW-1){1'b0}}, 1'b1};
    end
    else if (st_ff.cnt != '1)
    begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign done_o   = st_ff.done;
  assign period_o = st_ff.period;

endmodule

// ===== core/srdc_rate_checker.sv
`timescale 1ns/10ps
// Classifies a rate code: family, value in 10 Hz units, legality
module srdc_rate_checker
  import srdc_pkg::*;
(
  input  wire logic [4:0]  code_i,
  output logic             valid_o,
  output logic             frac_o,
  output logic [17:0]      hz10_o
);

  // Rate in units of 10 Hz, so 11.025 kHz stays exact enough
  always_comb
  begin
    valid_o = 1'b1;
    frac_o  = 1'b0;
    hz10_o  = 18'h0;
    unique case (code_i)
      SRDC_R12K:  hz10_o = 18'd1200;
      SRDC_R24K:  hz10_o = 18'd2400;
      SRDC_R48K:  hz10_o = 18'd4800;
      SRDC_R96K:  hz10_o = 18'd9600;
      SRDC_R192K: hz10_o = 18'd19200;
      SRDC_R8K:   hz10_o = 18'd800;
      SRDC_R16K:  hz10_o = 18'd1600;
      SRDC_R32K:  hz10_o = 18'd3200;
      SRDC_R11K:  begin hz10_o = 18'd1103;  frac_o = 1'b1; end
      SRDC_R22K:  begin hz10_o = 18'd2205;  frac_o = 1'b1; end
      SRDC_R44K:  begin hz10_o = 18'd4410;  frac_o = 1'b1; end
      SRDC_R88K:  begin hz10_o = 18'd8820;  frac_o = 1'b1; end
      SRDC_R176K: begin hz10_o = 18'd17640; frac_o = 1'b1; end
      default:    valid_o = 1'b0;
    endcase
  end

endmodule

// ===== core/srdc_top.sv
`timescale 1ns/10ps
// Summary of operation
// RQ1 - Five selectors, every rate held between 8 and 192 kHz.
// RQ2 - Three main selectors share one family with the main clock code.
// RQ3 - Two second-domain selectors share one family.
// RQ4 - Each path binds to exactly one of five selectors.
// RQ5 - Unsynchronised equal-rate interfaces go into different domains (software).
// RQ6 - Writes apply at a frame boundary, then show in applied fields.
// RQ7 - Converter paths stay in the main domain (software).
// RQ8 - External clocks stay within 1% of programmed value (software).
// RQ9 - Input path rate limited to 48/96 kHz for fast microphone clocks.
// RQ10 - Digital transmitter accepts only 32 to 192 kHz.
// RQ11 - Async converter rate ratio at most 6 (software).
// RQ12 - Isochronous converter rates integer multiples (software).
// RQ13 - Detection works only on slave interfaces.
// RQ14 - Enable bit and pin select control detection.
// RQ15 - Four candidates; other rates ignored.
// RQ16 - Match launches the sequence for that candidate.
// RQ17 - First-trigger bit low ignores first match, triggers on change.
// RQ18 - First-trigger bit high triggers on every new match.
// RQ19 - Pin change or re-enable restarts, next match may trigger.
// RQ20 - No duplicate or 192/176.4 and 96/88.2 candidate pairs (software).
// RQ21 - Main selectors from one family, matching the family bit.
// RQ22 - Three-bit clock code, 000 lowest, 100 highest.
module srdc_top
  import srdc_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic [SRDC_NSEL*5-1:0]      rate_select_i,
  input  wire logic [SRDC_NSEL-1:0]        rate_write_i,
  input  wire logic [SRDC_NSEL-1:0]        domain_frame_i,
  input  wire logic [2:0]                  main_clock_freq_code_i,
  input  wire logic                        rate_family_bit_i,
  input  wire logic [SRDC_NPATH*3-1:0]     path_bind_i,
  input  wire logic [1:0]                  mic_clock_sel_i,
  input  wire logic [2:0]                  input_path_idx_i,
  input  wire logic [2:0]                  spdif_path_idx_i,
  input  wire logic                        rate_detect_enable_i,
  input  wire logic [1:0]                  detect_pin_select_i,
  input  wire logic                        first_detect_trigger_i,
  input  wire logic [SRDC_NPIN-1:0]        pin_slave_i,
  input  wire logic [SRDC_NPIN-1:0]        frame_pin_i,
  input  wire logic [SRDC_NCAND*5-1:0]     cand_rate_i,
  output logic [SRDC_NSEL*5-1:0]           rate_applied_o,
  output logic                             main_cfg_err_o,
  output logic                             second_cfg_err_o,
  output logic                             path_err_o,
  output logic                             input_rate_err_o,
  output logic                             spdif_rate_err_o,
  output logic                             seq_launch_o,
  output logic [1:0]                       seq_index_o,
  output logic [4:0]                       detected_rate_o
);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0]           rst_sync_ff;
  logic                 rst_n;
  logic [SRDC_NPIN-1:0] pin_meta_ff;
  logic [SRDC_NPIN-1:0] pin_sync_ff;

  // Reset is asserted at once and released through two stages
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Frame pins come from other clocks
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= frame_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ****************************************************************
  // Rate classification of selectors and candidates
  // ****************************************************************
  logic [SRDC_NSEL-1:0]  sel_valid;
  logic [SRDC_NSEL-1:0]  sel_frac;
  logic [17:0]           sel_hz [SRDC_NSEL];
  logic [SRDC_NCAND-1:0] cand_valid;
  logic [17:0]           cand_hz [SRDC_NCAND];

  // Checks the applied values, since those are what the paths use
  genvar gi;
  generate
    for (gi = 0; gi < SRDC_NSEL; gi++)
    begin : g_sel
      srdc_rate_checker u_chk (
        .code_i  (rate_applied_o[gi*5 +: 5]),
        .valid_o (sel_valid[gi]),
        .frac_o  (sel_frac[gi]),
        .hz10_o  (sel_hz[gi])
      );
    end
    for (gi = 0; gi < SRDC_NCAND; gi++)
    begin : g_cand
      srdc_rate_checker u_chk (
        .code_i  (cand_rate_i[gi*5 +: 5]),
        .valid_o (cand_valid[gi]),
        .frac_o  (),
        .hz10_o  (cand_hz[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Frame-clock period measurement on the selected pin
  // ****************************************************************
  logic                 meter_done;
  logic [SRDC_PERW-1:0] meter_period;
  logic                 meter_run;

  // RQ13 slave-only measure
  // RQ14 enable and pin select
  assign meter_run = rate_detect_enable_i && pin_slave_i[detect_pin_select_i];

  srdc_period_meter u_meter (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .frame_i  (pin_sync_ff[detect_pin_select_i]),
    .run_i    (meter_run),
    .done_o   (meter_done),
    .period_o (meter_period)
  );

  // ****************************************************************
  // Registered state
  // ****************************************************************
  typedef enum logic [1:0] {
    SRDC_DET_IDLE,
    SRDC_DET_FIRST,
    SRDC_DET_TRACK
  } srdc_det_t;

  typedef struct packed {
    logic [SRDC_NSEL*5-1:0]  pend;
    logic [SRDC_NSEL-1:0]    pend_vld;
    logic [SRDC_NSEL*5-1:0]  applied;
    srdc_det_t               det;
    logic [1:0]              pin_last;
    logic [2:0]              cand_cur;
    logic [2:0]              cand_seen;
    logic [1:0]              confirm;
    logic                    launch;
    logic [1:0]              idx;
    logic [4:0]              detected;
    logic                    main_err;
    logic                    second_err;
    logic                    path_err;
    logic                    in_err;
    logic                    spd_err;
  } srdc_state_t;

  srdc_state_t st_ff;
  srdc_state_t nxt_st;

  // Period window of one candidate, 1% plus one clock either side
  function automatic logic cand_hit(input logic [17:0] hz10, input logic [SRDC_PERW-1:0] per);
    logic [31:0] expect_c;
    logic [31:0] tol;
    expect_c = 32'(SRDC_CLK_KHZ * 100) / ((hz10 == 18'h0) ? 32'h1 : 32'(hz10));
    tol      = (expect_c * 32'(SRDC_TOL_PCT)) / 32'h64 + 32'h1;
    cand_hit = (hz10 != 18'h0) && (32'(per) + tol >= expect_c) && (32'(per) <= expect_c + tol);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic [2:0]  hit;
    logic [17:0] in_hz;
    logic [17:0] spd_hz;
    logic [2:0]  b;
    hit    = 3'h4;
    in_hz  = 18'h0;
    spd_hz = 18'h0;
    b      = 3'h0;
    nxt_st = st_ff;
    nxt_st.launch = 1'b0;

    // RQ6 defer to boundary
    for (int i = 0; i < SRDC_NSEL; i++)
    begin
      if (rate_write_i[i])
      begin
        nxt_st.pend[i*5 +: 5] = rate_select_i[i*5 +: 5];
        nxt_st.pend_vld[i]    = 1'b1;
      end
      else if (st_ff.pend_vld[i] && domain_frame_i[i])
      begin
        nxt_st.applied[i*5 +: 5] = st_ff.pend[i*5 +: 5];
        nxt_st.pend_vld[i]       = 1'b0;
      end
    end

    // RQ21 one family
    // RQ22 clock code range
    // RQ2 main selectors related
    // RQ1 rates in range
    nxt_st.main_err = (main_clock_freq_code_i > SRDC_FREQ_MAX);
    for (int i = 0; i < SRDC_NSYNC; i++)
      if (!sel_valid[i] || sel_frac[i] != rate_family_bit_i)
        nxt_st.main_err = 1'b1;

    // RQ3 second selectors related
    nxt_st.second_err = !sel_valid[3] || !sel_valid[4] || (sel_frac[3] != sel_frac[4]);

    // RQ4 one selector each
    nxt_st.path_err = 1'b0;
    for (int p = 0; p < SRDC_NPATH; p++)
      if (path_bind_i[p*3 +: 3] >= 3'(SRDC_NSEL))
        nxt_st.path_err = 1'b1;

    // RQ9 microphone limit
    b = path_bind_i[input_path_idx_i*3 +: 3];
    if (b < 3'(SRDC_NSEL))
      in_hz = sel_hz[b];
    nxt_st.in_err = (mic_clock_sel_i == SRDC_MIC_384K && in_hz > 18'd4800) ||
                    (mic_clock_sel_i == SRDC_MIC_768K && in_hz > 18'd9600);

    // RQ10 transmitter range
    b = path_bind_i[spdif_path_idx_i*3 +: 3];
    if (b < 3'(SRDC_NSEL))
      spd_hz = sel_hz[b];
    nxt_st.spd_err = (spd_hz < 18'd3200) || (spd_hz > 18'd19200);

    // RQ15 candidates only
    for (int c = SRDC_NCAND - 1; c >= 0; c--)
      if (cand_valid[c] && cand_hit(cand_hz[c], meter_period))
        hit = 3'(c);

    // RQ19 restart on pin change or disable
    nxt_st.pin_last = detect_pin_select_i;
    if (!meter_run || detect_pin_select_i != st_ff.pin_last)
    begin
      nxt_st.det       = SRDC_DET_IDLE;
      nxt_st.cand_seen = 3'h4;
      nxt_st.confirm   = 2'h0;
    end
    else if (meter_done && !hit[2])
    begin
      // Two matches of one candidate, with no other candidate matched between, before acting, against noise
      if (hit != st_ff.cand_cur)
      begin
        nxt_st.cand_cur = hit;
        nxt_st.confirm  = 2'h1;
      end
      else if (st_ff.confirm < 2'(SRDC_CONFIRM))
      begin
        nxt_st.confirm = st_ff.confirm + 2'h1;
      end
      if (hit == st_ff.cand_cur && st_ff.confirm == 2'(SRDC_CONFIRM - 1) && hit != st_ff.cand_seen)
      begin
        nxt_st.cand_seen = hit;
        nxt_st.detected  = cand_rate_i[hit[1:0]*5 +: 5];
        unique case (st_ff.det)
          SRDC_DET_IDLE:
          begin
            // RQ18 trigger on first
            // RQ17 ignore first
            nxt_st.launch = first_detect_trigger_i;
            nxt_st.det    = SRDC_DET_TRACK;
          end
          SRDC_DET_FIRST,
          SRDC_DET_TRACK:
          begin
            // RQ16 per-candidate sequence
            nxt_st.launch = 1'b1;
            nxt_st.det    = SRDC_DET_TRACK;
          end
        endcase
        nxt_st.idx = hit[1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff          <= '0;
      st_ff.applied  <= {SRDC_NSEL{SRDC_RATE_RST}};
      st_ff.pend     <= {SRDC_NSEL{SRDC_RATE_RST}};
      st_ff.det      <= SRDC_DET_IDLE;
      st_ff.cand_cur <= 3'h4;
      st_ff.cand_seen <= 3'h4;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rate_applied_o   = st_ff.applied;
  assign main_cfg_err_o   = st_ff.main_err;
  assign second_cfg_err_o = st_ff.second_err;
  assign path_err_o       = st_ff.path_err;
  assign input_rate_err_o = st_ff.in_err;
  assign spdif_rate_err_o = st_ff.spd_err;
  assign seq_launch_o     = st_ff.launch;
  assign seq_index_o      = st_ff.idx;
  assign detected_rate_o  = st_ff.detected;

endmodule

// ===== test/srdc_top_sva.sv
`timescale 1ns/10ps
// ****
// Checker on the top ports
// ****
module srdc_top_sva
  import srdc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [24:0] rate_select_i,
  input wire logic [4:0]  rate_write_i,
  input wire logic [4:0]  domain_frame_i,
  input wire logic [2:0]  main_clock_freq_code_i,
  input wire logic        rate_family_bit_i,
  input wire logic [23:0] path_bind_i,
  input wire logic [1:0]  mic_clock_sel_i,
  input wire logic [2:0]  input_path_idx_i,
  input wire logic [2:0]  spdif_path_idx_i,
  input wire logic [19:0] cand_rate_i,
  input wire logic [24:0] rate_applied_o,
  input wire logic        main_cfg_err_o,
  input wire logic        second_cfg_err_o,
  input wire logic        path_err_o,
  input wire logic        input_rate_err_o,
  input wire logic        spdif_rate_err_o,
  input wire logic        seq_launch_o,
  input wire logic [1:0]  seq_index_o,
  input wire logic [4:0]  detected_rate_o
);
  logic       bb;
  logic       same;
  logic       mb;
  logic [2:0] is;
  logic [2:0] ss;
  logic [4:0] ic;
  logic [4:0] sc;

  function automatic logic f44(input logic [4:0] c);
    return c inside {5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
  endfunction

  // Decode bound paths; family and rate flags only judged once selectors equal applied copies
  always_comb
  begin
    bb = 1'b0;
    for (int k = 0; k < 8; k++)
      bb = bb | (path_bind_i[k*3 +: 3] > 3'h4);
    same = rate_select_i == rate_applied_o;
    mb = 1'b0;
    for (int k = 0; k < 3; k++)
      mb = mb | (f44(rate_applied_o[k*5 +: 5]) != rate_family_bit_i);
    is = path_bind_i[input_path_idx_i*3 +: 3];
    ss = path_bind_i[spdif_path_idx_i*3 +: 3];
    ic = (is < 3'h5) ? rate_applied_o[is*5 +: 5] : 5'h00;
    sc = (ss < 3'h5) ? rate_applied_o[ss*5 +: 5] : 5'h00;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  for (genvar k = 0; k < 5; k++)
  begin : g_app
    chk_apply_frame: assert property ($changed(rate_applied_o[k*5 +: 5]) |->
      $past(domain_frame_i[k] && !rate_write_i[k]))
      else $error("applied code moved without a frame");
  end
  chk_launch_single: assert property (seq_launch_o |=> !seq_launch_o)
    else $error("launch longer than one cycle");
  chk_launch_cand: assert property (seq_launch_o |->
    detected_rate_o != 5'h00 && detected_rate_o == cand_rate_i[seq_index_o*5 +: 5])
    else $error("launch rate not the indexed candidate");
  chk_path_bind: assert property (path_err_o == $past(bb))
    else $error("path flag wrong");
  chk_main_family: assert property ($past(same && main_clock_freq_code_i <= 3'h4) |->
    main_cfg_err_o == $past(mb))
    else $error("main family flag wrong");
  chk_freq_code: assert property ($past(main_clock_freq_code_i > 3'h4) |-> main_cfg_err_o)
    else $error("clock code above range not flagged");
  chk_second_family: assert property ($past(same) |->
    second_cfg_err_o == $past(f44(rate_applied_o[19:15]) != f44(rate_applied_o[24:20])))
    else $error("second family flag wrong");
  chk_input_limit: assert property ($past(same && is < 3'h5) |->
    input_rate_err_o == $past((mic_clock_sel_i == 2'h1 && ic inside {5'h04, 5'h05, 5'h0c, 5'h0d}) ||
                              (mic_clock_sel_i == 2'h2 && ic inside {5'h05, 5'h0d})))
    else $error("input rate flag wrong");
  chk_spdif_range: assert property ($past(same && ss < 3'h5) |->
    spdif_rate_err_o == $past(sc inside {5'h01, 5'h02, 5'h09, 5'h0a, 5'h11, 5'h12}))
    else $error("transmitter rate flag wrong");
endmodule

bind srdc_top srdc_top_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .rate_select_i(rate_select_i),
  .rate_write_i(rate_write_i), .domain_frame_i(domain_frame_i), .main_clock_freq_code_i(main_clock_freq_code_i),
  .rate_family_bit_i(rate_family_bit_i), .path_bind_i(path_bind_i), .mic_clock_sel_i(mic_clock_sel_i),
  .input_path_idx_i(input_path_idx_i), .spdif_path_idx_i(spdif_path_idx_i), .cand_rate_i(cand_rate_i),
  .rate_applied_o(rate_applied_o), .main_cfg_err_o(main_cfg_err_o), .second_cfg_err_o(second_cfg_err_o),
  .path_err_o(path_err_o), .input_rate_err_o(input_rate_err_o), .spdif_rate_err_o(spdif_rate_err_o),
  .seq_launch_o(seq_launch_o), .seq_index_o(seq_index_o), .detected_rate_o(detected_rate_o));

// ===== test/srdc_frame_src.sv
`timescale 1ns/10ps
// ****
// External frame clock source
// ****
module srdc_frame_src
(
  input  wire logic        clk_i,
  input  wire logic [15:0] period_i,
  output logic             frame_o
);
  logic [15:0] cnt = 16'h0000;

  initial frame_o = 1'b0;
  // exact period
  // Integer period keeps the rate well inside tolerance; zero parks low
  always @(posedge clk_i)
  begin
    cnt     <= (cnt + 16'h0001 >= period_i) ? 16'h0000 : cnt + 16'h0001;
    frame_o <= (period_i != 16'h0000) && (cnt < period_i / 2);
  end
endmodule

// ===== test/srdc_top_test.sv
`timescale 1ns/10ps
// ****
// Testbench
// ****
module srdc_top_test
  import srdc_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [24:0] sel = {5{5'h03}};
  logic [4:0]  wr = 5'h00;
  logic [4:0]  fr = 5'h00;
  logic [2:0]  fq = 3'h4;
  logic        fb = 1'b0;
  logic        en = 1'b0;
  logic        trg = 1'b1;
  logic [23:0] pb = 24'h000000;
  logic [1:0]  mic = 2'h0;
  logic [1:0]  psel = 2'h2;
  logic [2:0]  ip = 3'h0;
  logic [2:0]  sp = 3'h1;
  logic [3:0]  slv = 4'hf;
  logic [19:0] cand = {5'h00, 5'h00, 5'h04, 5'h03};
  logic [15:0] per [4] = '{default: 16'h0000};
  logic [4:0]  m [5] = '{default: 5'h03};
  logic [4:0]  r48 [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h11, 5'h12, 5'h13};
  logic [1:0]  gi;
  logic [4:0]  gr;
  wire  [3:0]  pin;
  wire  [24:0] app;
  wire         me, se, pe, ie, xe, ln;
  wire  [1:0]  li;
  wire  [4:0]  lr;
  int          seed = 40335;
  int          err_total = 0;
  int          checks = 0;
  int          nl = 0;

  always #50 clk = ~clk;

  srdc_top uut (.clk_i(clk), .reset_n_i(rst_n), .rate_select_i(sel), .rate_write_i(wr),
    .domain_frame_i(fr), .main_clock_freq_code_i(fq), .rate_family_bit_i(fb), .path_bind_i(pb),
    .mic_clock_sel_i(mic), .input_path_idx_i(ip), .spdif_path_idx_i(sp), .rate_detect_enable_i(en),
    .detect_pin_select_i(psel), .first_detect_trigger_i(trg), .pin_slave_i(slv), .frame_pin_i(pin),
    .cand_rate_i(cand), .rate_applied_o(app), .main_cfg_err_o(me), .second_cfg_err_o(se),
    .path_err_o(pe), .input_rate_err_o(ie), .spdif_rate_err_o(xe), .seq_launch_o(ln),
    .seq_index_o(li), .detected_rate_o(lr));

  for (genvar p = 0; p < 4; p++)
  begin : g_src
    srdc_frame_src u_src (.clk_i(clk), .period_i(per[p]), .frame_o(pin[p]));
  end

  // Launch monitor, sampled mid-cycle to avoid edge races
  always @(negedge clk)
    if (ln === 1'b1)
    begin
      nl++;
      gi = li;
      gr = lr;
    end

  function automatic logic f44(input logic [4:0] c);
    return c inside {5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
  endfunction

  function automatic logic lim(input logic [4:0] c, input logic [1:0] k);
    return (k == 2'h1 && c inside {5'h04, 5'h05, 5'h0c, 5'h0d}) || (k == 2'h2 && c inside {5'h05, 5'h0d});
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Write one selector, hold it pending, then give its frame
  task automatic put(input int s, input logic [4:0] c, input int gap);
    logic [4:0] old;
    old = app[s*5 +: 5];
    @(posedge clk);
    sel[s*5 +: 5] <= c;
    wr[s] <= 1'b1;
    @(posedge clk);
    wr[s] <= 1'b0;
    tick(gap);
    @(negedge clk);
    check("held", app[s*5 +: 5], old);
    @(posedge clk);
    fr[s] <= 1'b1;
    @(posedge clk);
    fr[s] <= 1'b0;
    @(negedge clk);
    check("applied", app[s*5 +: 5], c);
    m[s] = c;
  endtask

  // Compare all status flags with the model of applied codes
  task automatic errs();
    logic       b;
    logic [2:0] i;
    logic [2:0] s;
    tick(2);
    @(negedge clk);
    b = 1'b0;
    for (int k = 0; k < 8; k++)
      b = b | (pb[k*3 +: 3] > 3'h4);
    i = pb[ip*3 +: 3];
    s = pb[sp*3 +: 3];
    check("main_err", me, f44(m[0]) != fb || f44(m[1]) != fb || f44(m[2]) != fb || fq > 3'h4);
    check("second_err", se, f44(m[3]) != f44(m[4]));
    check("path_err", pe, b);
    check("input_err", ie, lim(m[i], mic));
    check("spdif_err", xe, m[s] inside {5'h01, 5'h02, 5'h09, 5'h0a, 5'h11, 5'h12});
  endtask

  // One detection window; launches counted by the monitor
  task automatic det(input int n, input logic [1:0] x, input logic [4:0] r);
    @(posedge clk);
    nl = 0;
    tick(3000);
    check("launches", nl, n);
    if (n > 0)
    begin
      check("index", gi, x);
      check("rate", gr, r);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well past the detection windows
  initial
  begin
    tick(45000);
    err_total++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    tick(8);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
    @(negedge clk);
    check("reset_rates", app, {5{5'h03}});
    errs();
    $display("Test reset done");
    @(posedge clk);
    sel[4:0] <= 5'h05;
    wr[0] <= 1'b1;
    fr[0] <= 1'b1;
    @(posedge clk);
    wr[0] <= 1'b0;
    fr[0] <= 1'b0;
    tick(2);
    @(negedge clk);
    check("deferred", app[4:0], 5'h03);
    put(0, 5'h05, 0);
    for (int i = 0; i < 24; i++)
    begin
      put($unsigned($random(seed)) % 5, r48[$unsigned($random(seed)) % 8], $unsigned($random(seed)) % 6);
      errs();
    end
    for (int k = 0; k < 5; k++)
      put(k, 5'h03, 0);
    $display("Test apply done");
    put(1, 5'h0b, 1);
    errs();
    @(posedge clk);
    fb <= 1'b1;
    put(0, 5'h09, 0);
    put(1, 5'h0b, 0);
    put(2, 5'h0d, 0);
    errs();
    @(posedge clk);
    fq <= 3'h5;
    errs();
    @(posedge clk);
    fq <= 3'h4;
    fb <= 1'b0;
    put(0, 5'h03, 0);
    put(1, 5'h13, 0);
    put(2, 5'h05, 0);
    errs();
    put(4, 5'h0b, 2);
    errs();
    put(4, 5'h04, 0);
    @(posedge clk);
    pb[17:15] <= 3'h5;
    errs();
    @(posedge clk);
    pb <= {15'h0000, 3'h2, 6'h08};
    ip <= 3'h2;
    mic <= 2'h1;
    errs();
    @(posedge clk);
    mic <= 2'h2;
    errs();
    put(2, 5'h04, 0);
    errs();
    @(posedge clk);
    mic <= 2'h1;
    errs();
    put(1, 5'h12, 0);
    errs();
    $display("Test flags done");
    @(posedge clk);
    per[1] <= 16'd208;
    per[2] <= 16'd208;
    en <= 1'b1;
    det(1, 2'h0, 5'h03);
    @(posedge clk);
    per[2] <= 16'd104;
    det(1, 2'h1, 5'h04);
    det(0, 2'h0, 5'h00);
    @(posedge clk);
    per[2] <= 16'd417;
    det(0, 2'h0, 5'h00);
    @(posedge clk);
    psel <= 2'h1;
    det(1, 2'h0, 5'h03);
    @(posedge clk);
    en <= 1'b0;
    per[1] <= 16'd104;
    det(0, 2'h0, 5'h00);
    @(posedge clk);
    trg <= 1'b0;
    en <= 1'b1;
    det(0, 2'h0, 5'h00);
    @(posedge clk);
    per[1] <= 16'd208;
    det(1, 2'h0, 5'h03);
    @(posedge clk);
    slv[1] <= 1'b0;
    per[1] <= 16'd104;
    det(0, 2'h0, 5'h00);
    $display("Test detect done");
    print_verdict();
  end
endmodule
